// ### design/nls_entry.v
/*
 * One neighbour entry: gain-step vector, step size, reverse link quality,
 * mains phase offset and the tone-map validity counter in minutes.
 * Assumes single-cycle event pulses from logic on hclk, and a one-cycle
 * minute tick from a shared divider.
 */
`include "nls_regs.vh"

module nls_entry (
   // clock and reset
   input  wire                      hclk,
   input  wire                      hresetn,
   // events addressed to this entry, plus the minute tick shared by all entries
   input  wire                      create,
   input  wire                      update,
   input  wire                      remove,
   input  wire                      tone_map_response,
   input  wire                      retry_fail,
   input  wire                      minute_tick,
   // configuration
   input  wire [`NLS_MIN_W-1:0]     default_minutes,
   input  wire [`NLS_MIN_W-1:0]     reload_minutes,
   // field data for create and update
   input  wire [`NLS_GAIN_W-1:0]    gain_steps_in,
   input  wire                      step_sel_in,
   input  wire [`NLS_LQ_W-1:0]      link_quality_in,
   input  wire [`NLS_PHASE_W-1:0]   phase_in,
   // stored state
   output reg                       valid_r,
   output reg  [`NLS_GAIN_W-1:0]    gain_steps_r,
   output reg                       step_sel_r,
   output reg  [`NLS_LQ_W-1:0]      link_quality_r,
   output reg  [`NLS_PHASE_W-1:0]   phase_r,
   output reg  [`NLS_MIN_W-1:0]     minutes_r
);

   // field storage; create and update both load the descriptive fields
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         valid_r        <= 1'b0;
         gain_steps_r   <= 48'h0000_0000_0000;
         step_sel_r     <= 1'b0;
         link_quality_r <= 8'h00;
         phase_r        <= 3'h0;
      end else begin
         if (create || update) begin
            gain_steps_r   <= gain_steps_in;    // see R01
            step_sel_r     <= step_sel_in;      // see R10
            link_quality_r <= link_quality_in;  // see R02
            phase_r        <= phase_in;         // see R03
         end
         if (create)
            valid_r <= 1'b1;
         else if (remove)
            valid_r <= 1'b0;
      end
   end

   // validity counter: create beats response, response beats failure,
   // each of these three beats the tick so a fresh load is never shortened
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         minutes_r <= 8'h00;
      end else if (create) begin
         minutes_r <= default_minutes;                 // see R05
      end else if (valid_r && tone_map_response) begin
         minutes_r <= reload_minutes;                  // see R07
      end else if (valid_r && retry_fail) begin
         minutes_r <= 8'h00;                           // see R08
      end else if (valid_r && minute_tick && minutes_r != 8'h00) begin
         minutes_r <= minutes_r - 8'h01;               // see R04 see R11
      end
   end

endmodule

// ### design/nls_table.v
/*
 * Neighbour link state table for the wide-band plan: an array of entries
 * updated by the MAC transmit and management logic, and exposed to software
 * as one attribute through an entry-select register and read windows on an
 * AHB-Lite slave with zero wait states.
 * Assumes all MAC-side inputs are pulses or levels from logic on hclk and
 * minute_tick is a one-cycle enable from a shared divider.
 * The window registers show one entry at a time: software rewrites the
 * entry select before reading another neighbour, which keeps the read mux
 * small at the cost of extra bus writes.
 * Writes to window or unmapped offsets are dropped, hsize is ignored and
 * every access is taken as one aligned word.
 */
// Operation
// R01 - each entry keeps 24 two-bit gain-step fields, group k at bits 2k+1:2k of 48 bits.
// R02 - each entry keeps an eight-bit reverse link quality value.
// R03 - each entry keeps a three-bit mains phase offset in 60 degree units.
// R04 - each entry keeps an eight-bit count of remaining valid minutes.
// R05 - creating an entry loads its count with the configured default.
// R06 - a tone-map request is raised only for a zero count while sending to that neighbour.
// R07 - a successful tone-map response reloads the count with the configured reload value.
// R08 - failing after the retry limit forces the count to zero.
// R09 - the whole table is readable by management as one attribute.
// R10 - a one-bit selector per entry picks 6 dB (0) or 3 dB (1) per gain step.
// R11 - the count drops by one per minute tick and holds at zero.
`include "nls_regs.vh"

module nls_table (
   // clock and reset
   input  wire                      hclk,
   input  wire                      hresetn,
   // ahb-lite slave
   input  wire                      hsel,
   input  wire [31:0]               haddr,
   input  wire [1:0]                htrans,
   input  wire                      hwrite,
   input  wire [2:0]                hsize,
   input  wire [31:0]               hwdata,
   input  wire                      hready,
   output reg                       hreadyout,
   output reg                       hresp,
   output reg  [31:0]               hrdata,
   // entry management from the mac
   input  wire                      ent_create,
   input  wire                      ent_update,
   input  wire                      ent_remove,
   input  wire [`NLS_IDX_W-1:0]     ent_index,
   input  wire [`NLS_GAIN_W-1:0]    tone_group_gain_steps,
   input  wire                      gain_step_size_select,
   input  wire [`NLS_LQ_W-1:0]      reverse_link_quality,
   input  wire [`NLS_PHASE_W-1:0]   mains_phase_offset,
   // tone-map response and transmit failure reports
   input  wire                      tone_map_response,
   input  wire [`NLS_IDX_W-1:0]     rsp_index,
   input  wire                      tx_fail,
   input  wire [`NLS_RETRY_W-1:0]   tx_fail_attempts,
   input  wire [`NLS_IDX_W-1:0]     fail_index,
   // data send and minute tick
   input  wire                      tx_send,
   input  wire [`NLS_IDX_W-1:0]     tx_index,
   input  wire                      minute_tick,
   // tone-map request to the mac
   output reg                       tone_map_request_r,
   output reg  [`NLS_IDX_W-1:0]     tone_map_request_index_r
);

   // table depth is fixed; the index ports are sized to match
   localparam N = `NLS_ENTRIES;

   // configuration registers
   // the retry limit is compared against the attempt count of each failure report
   reg  [`NLS_MIN_W-1:0]   tone_map_default_r;
   reg  [`NLS_MIN_W-1:0]   tone_map_validity_reload_r;
   reg  [`NLS_RETRY_W-1:0] frame_retry_limit_r;
   reg  [`NLS_IDX_W-1:0]   entry_sel_r;
   reg  [`NLS_MIN_W-1:0]   tone_map_default_nxt;
   reg  [`NLS_MIN_W-1:0]   tone_map_validity_reload_nxt;
   reg  [`NLS_RETRY_W-1:0] frame_retry_limit_nxt;
   reg  [`NLS_IDX_W-1:0]   entry_sel_nxt;

   // bus pipeline state
   reg                     wr_pend_r;
   reg  [7:0]              wr_addr_r;
   reg  [31:0]             hrdata_nxt;
   wire                    addr_ok;

   // entry state, flattened per field
   // flattened buses keep the per-slot slicing in one place
   wire [N-1:0]            valid_all;
   wire [N*48-1:0]         gain_all;
   wire [N-1:0]            step_all;
   wire [N*8-1:0]          lq_all;
   wire [N*3-1:0]          phase_all;
   wire [N*8-1:0]          min_all;
   wire                    fail_hit;

   // failure only counts once the retry limit has been spent
   // a report with fewer attempts is a retry in progress, not a failure
   assign fail_hit = tx_fail && (tx_fail_attempts >= frame_retry_limit_r); // see R08
   // a transfer is taken only when the bus is ready and the slave is selected
   assign addr_ok  = hsel && htrans[1] && hready;

   // one entry per table slot
   // every event port but minute_tick is decoded per slot, so different slots may be hit at once
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : gen_ent
         nls_entry u_entry (
            .hclk            (hclk),
            .hresetn         (hresetn),
            .create          (ent_create && ent_index == g),
            .update          (ent_update && ent_index == g),
            .remove          (ent_remove && ent_index == g),
            .tone_map_response (tone_map_response && rsp_index == g),
            .retry_fail      (fail_hit && fail_index == g),
            .minute_tick     (minute_tick),
            .default_minutes (tone_map_default_r),
            .reload_minutes  (tone_map_validity_reload_r),
            .gain_steps_in   (tone_group_gain_steps),
            .step_sel_in     (gain_step_size_select),
            .link_quality_in (reverse_link_quality),
            .phase_in        (mains_phase_offset),
            .valid_r         (valid_all[g]),
            .gain_steps_r    (gain_all[g*48 +: 48]),
            .step_sel_r      (step_all[g]),
            .link_quality_r  (lq_all[g*8 +: 8]),
            .phase_r         (phase_all[g*3 +: 3]),
            .minutes_r       (min_all[g*8 +: 8])
         );
      end
   endgenerate

   // register next values; a write lands in its data phase
   // the write data only stands in the data phase, hence the pending flag
   always @* begin
      tone_map_default_nxt         = tone_map_default_r;
      tone_map_validity_reload_nxt = tone_map_validity_reload_r;
      frame_retry_limit_nxt        = frame_retry_limit_r;
      entry_sel_nxt                = entry_sel_r;
      if (wr_pend_r) begin
         case (wr_addr_r)
            `NLS_OFF_DEFAULT: tone_map_default_nxt         = hwdata[7:0];
            `NLS_OFF_RELOAD:  tone_map_validity_reload_nxt = hwdata[7:0];
            `NLS_OFF_RETRY:   frame_retry_limit_nxt        = hwdata[3:0];
            `NLS_OFF_SEL:     entry_sel_nxt                = hwdata[2:0];
            default:          entry_sel_nxt                = entry_sel_r;
         endcase
      end
   end

   // read mux built from next values, so a read right behind a write
   // sees the new setting without a wait state
   always @* begin
      hrdata_nxt = 32'h0000_0000;
      // narrow fields sit low in each settings word; spare bits read as zero
      case (haddr[7:0])
         `NLS_OFF_DEFAULT: hrdata_nxt = {24'h00_0000, tone_map_default_nxt};
         `NLS_OFF_RELOAD:  hrdata_nxt = {24'h00_0000, tone_map_validity_reload_nxt};
         `NLS_OFF_RETRY:   hrdata_nxt = {28'h000_0000, frame_retry_limit_nxt};
         `NLS_OFF_SEL:     hrdata_nxt = {29'h0000_0000, entry_sel_nxt};
         `NLS_OFF_GAIN_LO: hrdata_nxt = gain_all[entry_sel_nxt*48 +: 32];        // see R09
         `NLS_OFF_GAIN_HI: hrdata_nxt = {15'h0000, step_all[entry_sel_nxt],
                                         gain_all[entry_sel_nxt*48+32 +: 16]};   // see R09
         `NLS_OFF_LINK:    hrdata_nxt = {valid_all[entry_sel_nxt], 7'h00,
                                         min_all[entry_sel_nxt*8 +: 8], 5'h00,
                                         phase_all[entry_sel_nxt*3 +: 3],
                                         lq_all[entry_sel_nxt*8 +: 8]};         // see R09
         default:          hrdata_nxt = 32'h0000_0000;
      endcase
   end

   // bus slave: always ready, always okay, unmapped reads give zero
   // hreadyout is low in reset so no transfer is taken before the flops settle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_r <= addr_ok && hwrite;
         if (addr_ok)
            wr_addr_r <= haddr[7:0];
         // read data is captured once and then held for the whole data phase
         if (addr_ok && !hwrite)
            hrdata <= hrdata_nxt;
      end
   end

   // configuration registers
   // settings change only through the write path above
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tone_map_default_r         <= `NLS_RST_DEFAULT;
         tone_map_validity_reload_r <= `NLS_RST_RELOAD;
         frame_retry_limit_r        <= `NLS_RST_RETRY;
         entry_sel_r                <= `NLS_RST_SEL;
      end else begin
         tone_map_default_r         <= tone_map_default_nxt;
         tone_map_validity_reload_r <= tone_map_validity_reload_nxt;
         frame_retry_limit_r        <= frame_retry_limit_nxt;
         entry_sel_r                <= entry_sel_nxt;
      end
   end

   // tone-map request: only while sending to a valid entry whose count is spent;
   // the mac decides whether to act, this only grants permission
   // the index follows every send so the mac can match the request to its frame
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tone_map_request_r       <= 1'b0;
         tone_map_request_index_r <= 3'h0;
      end else begin
         tone_map_request_r <= tx_send && valid_all[tx_index]
                               && (min_all[tx_index*8 +: 8] == 8'h00);  // see R06
         if (tx_send)
            tone_map_request_index_r <= tx_index;
      end
   end

endmodule

// ### shared/nls_regs.vh
/*
 * Constants for the neighbour link state table: table depth, field widths,
 * register byte offsets on the AHB-Lite slave and reset values.
 * Assumes it is included by its bare name from design files.
 */
`ifndef NLS_REGS_VH
`define NLS_REGS_VH

// table geometry
`define NLS_ENTRIES        8
`define NLS_IDX_W          3
`define NLS_GROUPS         24
`define NLS_GAIN_W         48
`define NLS_LQ_W           8
`define NLS_PHASE_W        3
`define NLS_MIN_W          8
`define NLS_RETRY_W        4

// register byte offsets (aligned words)
`define NLS_OFF_DEFAULT    8'h00
`define NLS_OFF_RELOAD     8'h04
`define NLS_OFF_RETRY      8'h08
`define NLS_OFF_SEL        8'h0C
`define NLS_OFF_GAIN_LO    8'h10
`define NLS_OFF_GAIN_HI    8'h14
`define NLS_OFF_LINK       8'h18

// field positions inside the read windows
`define NLS_HI_STEP_BIT    16
`define NLS_LINK_PH_LSB    8
`define NLS_LINK_MIN_LSB   16
`define NLS_LINK_VALID_BIT 31

// reset values
`define NLS_RST_DEFAULT    8'h05
`define NLS_RST_RELOAD     8'h02
`define NLS_RST_RETRY      4'h5
`define NLS_RST_SEL        3'h0

`endif

// ### test/nls_mac_model.sv
/* partner model of the mac transmit and management logic driving table events.
   assumes each task is entered right after a rising edge of hclk. */
`include "nls_regs.vh"
module nls_mac_model (
   // clock
   input  logic                      hclk,
   // entry management
   output logic                      ent_create = 0,
   output logic                      ent_update = 0,
   output logic                      ent_remove = 0,
   output logic [`NLS_IDX_W-1:0]     ent_index = 0,
   output logic [`NLS_GAIN_W-1:0]    tone_group_gain_steps = 0,
   output logic                      gain_step_size_select = 0,
   output logic [`NLS_LQ_W-1:0]      reverse_link_quality = 0,
   output logic [`NLS_PHASE_W-1:0]   mains_phase_offset = 0,
   // responses and failures
   output logic                      tone_map_response = 0,
   output logic [`NLS_IDX_W-1:0]     rsp_index = 0,
   output logic                      tx_fail = 0,
   output logic [`NLS_RETRY_W-1:0]   tx_fail_attempts = 0,
   output logic [`NLS_IDX_W-1:0]     fail_index = 0,
   // sending and time
   output logic                      tx_send = 0,
   output logic [`NLS_IDX_W-1:0]     tx_index = 0,
   output logic                      minute_tick = 0
);
   timeunit 1ns;
   timeprecision 1ps;
   // each event is a one-cycle pulse; every task but send adds a spare edge to keep pulses apart
   task create(input logic [2:0] i, input logic [47:0] g, input logic s,
               input logic [7:0] q, input logic [2:0] p);
      ent_create <= 1'b1;
      ent_index <= i;
      tone_group_gain_steps <= g;
      gain_step_size_select <= s;
      reverse_link_quality <= q;
      mains_phase_offset <= p;
      @(posedge hclk);
      ent_create <= 1'b0;
      @(posedge hclk);
   endtask
   // rewrites the descriptive fields of a live entry; its count is left alone
   task update(input logic [2:0] i, input logic [47:0] g, input logic s,
               input logic [7:0] q, input logic [2:0] p);
      ent_update <= 1'b1;
      ent_index <= i;
      tone_group_gain_steps <= g;
      gain_step_size_select <= s;
      reverse_link_quality <= q;
      mains_phase_offset <= p;
      @(posedge hclk);
      ent_update <= 1'b0;
      @(posedge hclk);
   endtask
   task remove(input logic [2:0] i);
      ent_remove <= 1'b1;
      ent_index <= i;
      @(posedge hclk);
      ent_remove <= 1'b0;
      @(posedge hclk);
   endtask
   task respond(input logic [2:0] i);
      tone_map_response <= 1'b1;
      rsp_index <= i;
      @(posedge hclk);
      tone_map_response <= 1'b0;
      @(posedge hclk);
   endtask
   task fail(input logic [2:0] i, input logic [3:0] n);
      tx_fail <= 1'b1;
      tx_fail_attempts <= n;
      fail_index <= i;
      @(posedge hclk);
      tx_fail <= 1'b0;
      @(posedge hclk);
   endtask
   task tick;
      minute_tick <= 1'b1;
      @(posedge hclk);
      minute_tick <= 1'b0;
      @(posedge hclk);
   endtask
   // no spare edge: the request must be seen in the cycle after the send
   task send(input logic [2:0] i);
      tx_send <= 1'b1;
      tx_index <= i;
      @(posedge hclk);
      tx_send <= 1'b0;
   endtask
endmodule

// ### test/nls_table_chk.sv
/* checker on the table top ports: bus answers and request timing.
   assumes the table's hclk and active-low hresetn. */
`include "nls_regs.vh"
module nls_table_chk (
   // clock and reset
   input logic                  hclk,
   input logic                  hresetn,
   // bus
   input logic                  hsel,
   input logic [31:0]           haddr,
   input logic [1:0]            htrans,
   input logic                  hwrite,
   input logic                  hready,
   input logic                  hreadyout,
   input logic                  hresp,
   input logic [31:0]           hrdata,
   // tone-map request
   input logic                  tx_send,
   input logic [`NLS_IDX_W-1:0] tx_index,
   input logic                  tone_map_request_r,
   input logic [`NLS_IDX_W-1:0] tone_map_request_index_r
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // read address phase taken at this edge
   logic rd_go;
   assign rd_go = hsel & htrans[1] & hready & ~hwrite;
   chk_req_cause: assert property (tone_map_request_r |-> $past(tx_send))
      else $error("request without a send");
   chk_req_index: assert property (tx_send |=> tone_map_request_index_r == $past(tx_index))
      else $error("request index wrong");
   chk_req_drop: assert property (!tx_send |=> !tone_map_request_r)
      else $error("request stands too long");
   chk_ready_high: assert property (hresetn |=> hreadyout)
      else $error("slave not ready");
   chk_resp_okay: assert property (!hresp)
      else $error("response not okay");
   chk_unmapped_zero: assert property (rd_go && haddr[7:0] >= 8'h1C |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   chk_link_pad: assert property (rd_go && haddr[7:0] == 8'h18 |=> hrdata[30:24] == 7'h0
      && hrdata[15:11] == 5'h0)
      else $error("link word padding not zero");
   chk_rdata_hold: assert property (!rd_go |=> $stable(hrdata))
      else $error("read data moved");
   // main scenarios reached
   cover property (tone_map_request_r);
   cover property (rd_go && haddr[7:0] == 8'h18);
   cover property (tx_send ##2 tx_send);
endmodule

bind nls_table nls_table_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
   .hreadyout, .hresp, .hrdata, .tx_send, .tx_index, .tone_map_request_r,
   .tone_map_request_index_r);

// ### test/tb_top.sv
/* self-checking bench for the neighbour table: bus tasks, mac partner, checks.
   assumes the table answers the bus with no wait states. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, rdy_q;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_q, rd;
   logic ent_create, ent_update, ent_remove, gain_step_size_select, tone_map_response, tx_fail;
   logic tx_send, minute_tick, tone_map_request_r;
   logic [2:0] ent_index, mains_phase_offset, rsp_index, fail_index, tx_index;
   logic [2:0] tone_map_request_index_r;
   logic [3:0] tx_fail_attempts;
   logic [7:0] reverse_link_quality;
   logic [47:0] tone_group_gain_steps;
   int n_mismatch = 0, check_count = 0;
   logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C};
   logic [7:0] rv [5] = '{8'h05, 8'h02, 8'h05, 8'h00, 8'h00};
   localparam logic [47:0] GAIN_PAT = 48'h9B24_E1C7_5A36;
   nls_table dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ent_create, .ent_update, .ent_remove,
      .ent_index, .tone_group_gain_steps, .gain_step_size_select, .reverse_link_quality,
      .mains_phase_offset, .tone_map_response, .rsp_index, .tx_fail, .tx_fail_attempts,
      .fail_index, .tx_send, .tx_index, .minute_tick, .tone_map_request_r,
      .tone_map_request_index_r);
   nls_mac_model mac (.hclk, .ent_create, .ent_update, .ent_remove, .ent_index,
      .tone_group_gain_steps, .gain_step_size_select, .reverse_link_quality,
      .mains_phase_offset, .tone_map_response, .rsp_index, .tx_fail, .tx_fail_attempts,
      .fail_index, .tx_send, .tx_index, .minute_tick);
   always #4 hclk = ~hclk;
   // sample bus answers mid-cycle so edge updates never race the master
   always @(negedge hclk) begin
      rdy_q = hreadyout;
      rd_q = hrdata;
   end
   task print_verdict;
      if (n_mismatch == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // single transfer: address held until ready, then the data phase
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (rdy_q !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (rdy_q !== 1'b1);
      rd = rd_q;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
      ahb(1'b0, a, 32'h0);
      check(n, rd, e);
   endtask
   function automatic logic [31:0] lw(input logic v, input logic [7:0] m, input logic [2:0] p,
                                      input logic [7:0] q);
      return {v, 7'h0, m, 5'h0, p, q};
   endfunction
   task req(input logic [2:0] i, input logic e);
      mac.send(i);
      #1;
      check("request", {tone_map_request_index_r, tone_map_request_r}, {i, e});
      @(posedge hclk);
   endtask
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      for (int i = 0; i < 5; i++) rdc(ra[i], {24'h0, rv[i]}, "reset value");
      ahb(1'b1, 8'h00, 32'h3);
      ahb(1'b1, 8'h04, 32'h7);
      ahb(1'b1, 8'h08, 32'hFFFF_FFF5);
      rdc(8'h08, 32'h5, "retry limit");
      ahb(1'b1, 8'h0C, 32'h2);
      mac.create(3'h2, GAIN_PAT, 1'b1, 8'hB6, 3'h5);
      rdc(8'h10, GAIN_PAT[31:0], "gain low");
      rdc(8'h14, {15'h0, 1'b1, GAIN_PAT[47:32]}, "gain high");
      rdc(8'h18, lw(1'b1, 8'h3, 3'h5, 8'hB6), "link word");
      ahb(1'b1, 8'h18, 32'h0);
      rdc(8'h18, lw(1'b1, 8'h3, 3'h5, 8'hB6), "window write");
      req(3'h2, 1'b0);
      repeat (4) mac.tick();
      rdc(8'h18, lw(1'b1, 8'h0, 3'h5, 8'hB6), "minutes floor");
      req(3'h2, 1'b1);
      mac.respond(3'h2);
      rdc(8'h18, lw(1'b1, 8'h7, 3'h5, 8'hB6), "reload");
      mac.fail(3'h2, 4'h4);
      rdc(8'h18, lw(1'b1, 8'h7, 3'h5, 8'hB6), "fail below limit");
      mac.fail(3'h2, 4'h5);
      rdc(8'h18, lw(1'b1, 8'h0, 3'h5, 8'hB6), "fail at limit");
      mac.update(3'h2, ~GAIN_PAT, 1'b0, 8'h3C, 3'h1);
      rdc(8'h14, {15'h0, 1'b0, ~GAIN_PAT[47:32]}, "update gain high");
      rdc(8'h18, lw(1'b1, 8'h0, 3'h1, 8'h3C), "update link word");
      mac.remove(3'h2);
      req(3'h2, 1'b0);
      print_verdict;
   end
   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge hclk);
      n_mismatch++;
      print_verdict;
   end
endmodule
